/* hw/dwr_top.sv */
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Function
// - all host words enter one shift register
// - control word to control and buffer
// - buffer steers delay and address words
// - bits 20 to 23 select destination
// - addresses recirculated twice each dump tick
// - address store drives bus with enable
// - last flag marks final address word
// - start-up forces last flag to one
// - period change applied at dump boundary
// - store holds 54 delay and sampler words
// - words retained while being sent out
// - bad parity keeps the old delay or address word
// - left and right serial output registers
// - test holds get selected word minus five
// - test holds change after full set
// - left at E, right 3.2 us later
// - 8-bit sampler registers share shift clocks
// - sampler bytes recirculate, sent three times
// - shift on B D F H, capture others
// - parity result steers store recirculation
// - 64-deep store stepped by pulse generator
module dwr_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic host_clk,
    input wire logic host_data,
    input wire logic basic_time_in,
    output logic basic_time_tick,
    output logic dump_time_tick,
    output logic power_up_reset_pulse,
    output dwr_pkg::dwr_serial_t serial_out,
    output logic receive_capture_phases,
    output logic [dwr_pkg::DELAY_W-1:0] left_test_delay_hold,
    output logic [dwr_pkg::DELAY_W-1:0] right_test_delay_hold,
    output logic [dwr_pkg::ADDR_W-1:0] addr_bus_out,
    output logic addr_bus_oe,
    output logic addr_preset_pass,
    output logic addr_last_out
);
    import dwr_pkg::*;

    function automatic logic [DELAY_W-1:0] minus_offset(
        input logic [DATA_W-1:0] w);
        return w[DELAY_W-1:0] - DELAY_W'(TEST_OFFSET);
    endfunction

    logic [2:0] s1, s2, s3, lvl, lvl_d;
    logic hclk_rise, bt_pulse;
    logic [SU_W-1:0] su_cnt;
    logic [WORD_W-1:0] host_word_receive_shift_reg;
    logic [BITCNT_W-1:0] bit_cnt;
    logic word_done, buf_new, par_ok;
    logic [WORD_W-1:0] host_word_buffer;
    logic [DATA_W-1:0] control_word_register;
    logic [DATA_W-1:0] delay_word_store [STORE_DEPTH];
    logic [IDX_W-1:0] wr_idx;
    logic [PERR_W-1:0] perr_cnt;
    dwr_addr_entry_t requested_address_store [ADDR_WORDS];
    logic [AIDX_W-1:0] a_wr, a_rd;
    dwr_ap_state_t ap_state;
    logic [PER_W-1:0] period, bt_cnt;
    logic [CYC_W-1:0] cyc;
    logic [PHASE_W-1:0] phase;
    logic ph_tick;
    dwr_tx_state_t tx_state;
    logic [IDX_W-1:0] tx_idx, rd_idx;
    logic [LAG_W-1:0] lag_cnt;
    logic [SCNT_W-1:0] shift_cnt;
    logic load_l_ev, load_r_ev, shift_ev, set_done;
    logic [DATA_W-1:0] left_sr, right_sr, rd_word, wr_old;
    logic [SAMP_W-1:0] left_samp, right_samp;
    logic [DELAY_W-1:0] pend_l, pend_r;
    logic [IDX_W-1:0] test_l, test_r;
    logic [3:0] buf_code;
    logic apb_wr;

    // Three-stage sampling; level accepted when stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            lvl <= '0;
            lvl_d <= '0;
        end else begin
            s1 <= {basic_time_in, host_data, host_clk};
            s2 <= s1;
            s3 <= s2;
            lvl <= (lvl & (s2 ^ s3)) | (s3 & ~(s2 ^ s3));
            lvl_d <= lvl;
        end
    end
    assign hclk_rise = lvl[0] & ~lvl_d[0];
    assign bt_pulse = lvl[2] & ~lvl_d[2];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            su_cnt <= '0;
            power_up_reset_pulse <= 1'b1;
        end else begin
            power_up_reset_pulse <= su_cnt != SU_W'(SU_CYC - 1);
            if (su_cnt != SU_W'(SU_CYC - 1))
                su_cnt <= su_cnt + 1'b1;
        end
    end

    // word ends after 32 host clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_word_receive_shift_reg <= '0;
            bit_cnt <= '0;
            word_done <= 1'b0;
        end else begin
            word_done <= 1'b0;
            if (power_up_reset_pulse) begin
                bit_cnt <= '0;
            end else if (hclk_rise) begin
                host_word_receive_shift_reg <=
                    {host_word_receive_shift_reg[WORD_W-2:0], lvl[1]};
                bit_cnt <= bit_cnt + 1'b1;
                word_done <= bit_cnt == BITCNT_W'(WORD_W - 1);
            end
        end
    end

    // control word also lands in buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_word_buffer <= '0;
            control_word_register <= '0;
            buf_new <= 1'b0;
            par_ok <= 1'b0;
        end else begin
            buf_new <= word_done;
            if (word_done) begin
                host_word_buffer <= host_word_receive_shift_reg;
                par_ok <= ^host_word_receive_shift_reg[PAR_BIT:0];
                if (host_word_receive_shift_reg[CODE_LO +: CODE_W] ==
                    CODE_CONTROL)
                    control_word_register <=
                        host_word_receive_shift_reg[DATA_W-1:0];
            end
        end
    end
    assign buf_code = host_word_buffer[CODE_LO +: CODE_W];
    assign wr_old = delay_word_store[wr_idx];

    // 54 words in a 64-deep store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < STORE_DEPTH; i++)
                delay_word_store[i] <= '0;
            wr_idx <= '0;
            perr_cnt <= '0;
        end else if (buf_new && buf_code == CODE_DELAY) begin
            delay_word_store[wr_idx] <= par_ok ?
                host_word_buffer[DATA_W-1:0] : wr_old;
            wr_idx <= (wr_idx == IDX_W'(DELAY_WORDS - 1)) ?
                '0 : wr_idx + 1'b1;
            if (!par_ok && perr_cnt != '1)
                perr_cnt <= perr_cnt + 1'b1;
        end
    end

    // address words to the address store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < ADDR_WORDS; i++)
                requested_address_store[i] <= '0;
            requested_address_store[0].last <= 1'b1;
            a_wr <= '0;
        end else if (power_up_reset_pulse) begin
            requested_address_store[0].last <= 1'b1;
            a_wr <= '0;
        end else if (buf_new && buf_code == CODE_ADDR && par_ok) begin
            requested_address_store[a_wr] <=
                {host_word_buffer[ADDR_W-1:0],
                 host_word_buffer[ADDR_LAST_BIT]};
            if (host_word_buffer[ADDR_LAST_BIT])
                a_wr <= '0;
            else if (a_wr != AIDX_W'(ADDR_WORDS - 1))
                a_wr <= a_wr + 1'b1;
        end
    end

    // new period only at a dump boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period <= '0;
            bt_cnt <= '0;
            basic_time_tick <= 1'b0;
            dump_time_tick <= 1'b0;
        end else begin
            basic_time_tick <= bt_pulse;
            dump_time_tick <= bt_pulse && bt_cnt == period;
            if (bt_pulse) begin
                if (bt_cnt == period) begin
                    bt_cnt <= '0;
                    period <= control_word_register[PER_LO +: PER_W];
                end else begin
                    bt_cnt <= bt_cnt + 1'b1;
                end
            end
        end
    end

    // two readout passes per dump tick
    // bus driven with enable on both passes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ap_state <= AP_IDLE;
            a_rd <= '0;
            addr_bus_out <= '0;
            addr_bus_oe <= 1'b0;
            addr_preset_pass <= 1'b0;
            addr_last_out <= 1'b0;
        end else begin
            addr_bus_oe <= ap_state != AP_IDLE;
            addr_preset_pass <= ap_state == AP_PRESET;
            addr_bus_out <= requested_address_store[a_rd].addr;
            addr_last_out <= ap_state != AP_IDLE &&
                requested_address_store[a_rd].last;
            unique case (ap_state)
                AP_IDLE: begin
                    a_rd <= '0;
                    if (dump_time_tick)
                        ap_state <= AP_RAM;
                end
                AP_RAM, AP_PRESET: begin
                    if (requested_address_store[a_rd].last ||
                        a_rd == AIDX_W'(ADDR_WORDS - 1)) begin
                        a_rd <= '0;
                        ap_state <= ap_state == AP_RAM ? AP_PRESET : AP_IDLE;
                    end else begin
                        a_rd <= a_rd + 1'b1;
                    end
                end
            endcase
        end
    end

    // Eight phases A..H of 200 ns each
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc <= '0;
            phase <= '0;
            receive_capture_phases <= 1'b0;
        end else begin
            cyc <= (cyc == CYC_W'(PHASE_CYC - 1)) ? '0 : cyc + 1'b1;
            if (cyc == CYC_W'(PHASE_CYC - 1))
                phase <= phase + 1'b1;
            // capture marker on A C E G
            receive_capture_phases <= (cyc == CYC_W'(PHASE_CYC - 1)) ?
                phase[0] : ~phase[0];
        end
    end
    assign ph_tick = cyc == '0;

    assign load_l_ev = tx_state == TX_LOAD_L && ph_tick && phase == PH_E;
    assign load_r_ev = tx_state == TX_LOAD_R && ph_tick &&
        lag_cnt == LAG_W'(RIGHT_LAG_PHASES - 1);
    assign shift_ev = tx_state == TX_SHIFT && ph_tick && phase[0];
    assign rd_idx = (tx_state == TX_LOAD_R) ? tx_idx + 1'b1 : tx_idx;
    assign rd_word = delay_word_store[rd_idx];

    // left at E, right 16 phases later
    // next load only after 24 shifts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state <= TX_IDLE;
            tx_idx <= '0;
            lag_cnt <= '0;
            shift_cnt <= '0;
            set_done <= 1'b0;
        end else begin
            set_done <= 1'b0;
            unique case (tx_state)
                TX_IDLE: begin
                    tx_idx <= '0;
                    if (basic_time_tick)
                        tx_state <= TX_LOAD_L;
                end
                TX_LOAD_L: begin
                    lag_cnt <= '0;
                    if (load_l_ev)
                        tx_state <= TX_LOAD_R;
                end
                TX_LOAD_R: begin
                    shift_cnt <= '0;
                    if (load_r_ev)
                        tx_state <= TX_SHIFT;
                    else if (ph_tick)
                        lag_cnt <= lag_cnt + 1'b1;
                end
                TX_SHIFT: begin
                    if (shift_ev) begin
                        shift_cnt <= shift_cnt + 1'b1;
                        if (shift_cnt == SCNT_W'(SHIFT_PULSES - 1)) begin
                            if (tx_idx >= IDX_W'(DELAY_WORDS - 2)) begin
                                set_done <= 1'b1;
                                tx_state <= TX_IDLE;
                            end else begin
                                tx_idx <= tx_idx + IDX_W'(2);
                                tx_state <= TX_LOAD_L;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // sampler registers on the same clocks
    // shifts only on B D F H
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_sr <= '0;
            right_sr <= '0;
            left_samp <= '0;
            right_samp <= '0;
        end else if (load_l_ev) begin
            left_sr <= rd_word;
            left_samp <= rd_word[SAMP_W-1:0];
        end else if (load_r_ev) begin
            right_sr <= rd_word;
            right_samp <= rd_word[SAMP_W-1:0];
        end else if (shift_ev) begin
            left_sr <= {left_sr[DATA_W-2:0], 1'b0};
            right_sr <= {right_sr[DATA_W-2:0], 1'b0};
            left_samp <= {left_samp[SAMP_W-2:0], left_samp[SAMP_W-1]};
            right_samp <= {right_samp[SAMP_W-2:0], right_samp[SAMP_W-1]};
        end
    end
    assign serial_out = '{left_delay: left_sr[DATA_W-1],
                          right_delay: right_sr[DATA_W-1],
                          left_samp: left_samp[SAMP_W-1],
                          right_samp: right_samp[SAMP_W-1]};

    // holds update at end of set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_l <= '0;
            pend_r <= '0;
            left_test_delay_hold <= '0;
            right_test_delay_hold <= '0;
        end else begin
            if ((load_l_ev || load_r_ev) && rd_idx == test_l)
                pend_l <= minus_offset(rd_word);
            if ((load_l_ev || load_r_ev) && rd_idx == test_r)
                pend_r <= minus_offset(rd_word);
            if (set_done) begin
                left_test_delay_hold <= pend_l;
                right_test_delay_hold <= pend_r;
            end
        end
    end

    // APB slave, answers in the first access cycle
    assign apb_wr = psel && penable && pready && pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_l <= '0;
            test_r <= '0;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            if (apb_wr && paddr == REG_CTRL) begin
                test_l <= pwdata[CT_TL_LO +: IDX_W];
                test_r <= pwdata[CT_TR_LO +: IDX_W];
            end
            if (psel && !penable) begin
                prdata <= '0;
                pslverr <= 1'b0;
                unique case (paddr)
                    REG_CTRL: begin
                        prdata[CT_TL_LO +: IDX_W] <= test_l;
                        prdata[CT_TR_LO +: IDX_W] <= test_r;
                    end
                    REG_STATUS: begin
                        prdata[ST_ACTIVE] <= tx_state != TX_IDLE;
                        prdata[ST_PER_LO +: PER_W] <= period;
                        prdata[ST_PERR_LO +: PERR_W] <= perr_cnt;
                    end
                    REG_CONTROL_WORD:
                        prdata[DATA_W-1:0] <= control_word_register;
                    REG_TIME: prdata <= host_word_buffer;
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ctrl_copy;
        word_done && host_word_receive_shift_reg[CODE_LO +: CODE_W]
            == CODE_CONTROL |=> control_word_register ==
            host_word_buffer[DATA_W-1:0];
    endproperty
    a_ctrl_copy: assert property (p_ctrl_copy)
        else $error("control word not copied");

    property p_delay_write;
        buf_new && buf_code == CODE_DELAY && par_ok |=>
            delay_word_store[$past(wr_idx)] ==
            $past(host_word_buffer[DATA_W-1:0]);
    endproperty
    a_delay_write: assert property (p_delay_write)
        else $error("good delay word not stored");

    property p_parity_keep;
        buf_new && buf_code == CODE_DELAY && !par_ok |=>
            delay_word_store[$past(wr_idx)] == $past(wr_old);
    endproperty
    a_parity_keep: assert property (p_parity_keep)
        else $error("bad parity overwrote old word");

    property p_startup_flag;
        power_up_reset_pulse |-> requested_address_store[0].last;
    endproperty
    a_startup_flag: assert property (p_startup_flag)
        else $error("last flag missing at start-up");

    property p_right_lag;
        load_l_ev |-> ##128 load_r_ev;
    endproperty
    a_right_lag: assert property (p_right_lag)
        else $error("right load not 3.2 us after left");

    property p_shift_phase;
        shift_ev |-> phase[0] && !receive_capture_phases;
    endproperty
    a_shift_phase: assert property (p_shift_phase)
        else $error("shift outside B D F H");

    property p_hold_stable;
        !set_done |=> $stable(left_test_delay_hold) &&
            $stable(right_test_delay_hold);
    endproperty
    a_hold_stable: assert property (p_hold_stable)
        else $error("test hold changed mid-set");

    property p_bus_drive;
        dump_time_tick |-> ##2 addr_bus_oe && !addr_preset_pass;
    endproperty
    a_bus_drive: assert property (p_bus_drive)
        else $error("address bus not driven after dump tick");

    property p_period_hold;
        !bt_pulse |=> $stable(period);
    endproperty
    a_period_hold: assert property (p_period_hold)
        else $error("period changed off boundary");
endmodule
`default_nettype wire

/* hw/dwr_pkg.sv */
package dwr_pkg;
    // Host word layout
    localparam int WORD_W = 32;
    localparam int DATA_W = 24;
    localparam int CODE_LO = 20;
    localparam int CODE_W = 4;
    localparam int PAR_BIT = 24;
    localparam int BITCNT_W = 5;
    localparam logic [3:0] CODE_CONTROL = 4'h1;
    localparam logic [3:0] CODE_TIME = 4'h2;
    localparam logic [3:0] CODE_DELAY = 4'h3;
    localparam logic [3:0] CODE_ADDR = 4'h4;
    // Control word: dump period in basic ticks minus one
    localparam int PER_LO = 0;
    localparam int PER_W = 3;
    // Stores
    localparam int DELAY_WORDS = 54;
    localparam int STORE_DEPTH = 64;
    localparam int IDX_W = 6;
    localparam int DELAY_W = 20;
    localparam int TEST_OFFSET = 5;
    localparam int ADDR_WORDS = 351;
    localparam int AIDX_W = 9;
    localparam int ADDR_W = 12;
    localparam int ADDR_LAST_BIT = 12;
    localparam int SAMP_W = 8;
    localparam int SHIFT_PULSES = 24;
    localparam int SCNT_W = 5;
    // Timing
    localparam int CLK_NS = 25;
    localparam int PHASE_NS = 200;
    localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_W = 3;
    localparam int PHASE_W = 3;
    localparam logic [2:0] PH_E = 3'h4;
    localparam int RIGHT_LAG_NS = 3200;
    localparam int RIGHT_LAG_PHASES = RIGHT_LAG_NS / PHASE_NS;
    localparam int LAG_W = 5;
    localparam int SU_NS = 1000;
    localparam int SU_CYC = (SU_NS + CLK_NS - 1) / CLK_NS;
    localparam int SU_W = 6;
    // APB map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CONTROL_WORD = 8'h08;
    localparam logic [7:0] REG_TIME = 8'h0C;
    localparam int CT_TL_LO = 0;
    localparam int CT_TR_LO = 8;
    localparam int ST_ACTIVE = 0;
    localparam int ST_PER_LO = 4;
    localparam int ST_PERR_LO = 8;
    localparam int PERR_W = 8;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic last;
    } dwr_addr_entry_t;

    typedef struct packed {
        logic left_delay;
        logic right_delay;
        logic left_samp;
        logic right_samp;
    } dwr_serial_t;

    typedef enum logic [1:0] {TX_IDLE, TX_LOAD_L, TX_LOAD_R, TX_SHIFT}
        dwr_tx_state_t;
    typedef enum logic [1:0] {AP_IDLE, AP_RAM, AP_PRESET} dwr_ap_state_t;
endpackage

/* tb/dwr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dwr_host_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [31:0] word,
    input wire logic go,
    output logic host_clk,
    output logic host_data,
    output logic busy
);
    logic [7:0] cnt;
    logic [31:0] sh;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {host_clk, host_data, busy, cnt, sh} <= '0;
        end else if (!busy) begin
            if (go) begin
                busy <= 1'b1;
                sh <= word;
                cnt <= 8'h00;
            end
        end else begin
            cnt <= cnt + 8'h01;
            host_clk <= cnt[2];
            if (cnt[2:0] == 3'h0) begin
                host_data <= sh[31];
                sh <= sh << 1;
            end
            if (cnt == 8'hFF) begin
                busy <= 1'b0;
                host_clk <= 1'b0;
                // Idle line must not look like the last bit
                host_data <= ~host_data;
            end
        end
    end
endmodule
`default_nettype wire

/* tb/delay_word_receive_and_distribute_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module delay_word_receive_and_distribute_tb;
    import dwr_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, hword = '0, cw;
    logic pready, pslverr, host_clk, host_data, go = 0, busy;
    logic basic_time_in = 0, bt, dt, su, rcp, oe, pp, al;
    logic [DELAY_W-1:0] tl, tr;
    logic [ADDR_W-1:0] ab;
    dwr_serial_t so;
    logic [31:0] q_exp[$], q_msk[$];
    logic q_err[$];
    logic [15:0] lf = 16'h1A8A;
    logic [5:0] il;
    int mismatches = 0, num_checks = 0, dumps = 0, drives = 0, lasts = 0;
    int presets = 0, bts = 0;
    int rises[4] = '{default: 0};
    dwr_serial_t so_d = '0;

    dwr_top dwr_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .host_clk(host_clk), .host_data(host_data),
        .basic_time_in(basic_time_in), .basic_time_tick(bt),
        .dump_time_tick(dt), .power_up_reset_pulse(su), .serial_out(so),
        .receive_capture_phases(rcp), .left_test_delay_hold(tl),
        .right_test_delay_hold(tr), .addr_bus_out(ab), .addr_bus_oe(oe),
        .addr_preset_pass(pp), .addr_last_out(al));
    dwr_host_model dwr_host_model_i (.pclk(pclk), .presetn(presetn),
        .word(hword), .go(go), .host_clk(host_clk),
        .host_data(host_data), .busy(busy));

    initial forever #12.5 pclk = ~pclk;

    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        if (mismatches == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic hang;
        mismatches++;
        final_report();
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
            if (n > 50) hang();
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m, input logic er);
        q_exp.push_back(e & m);
        q_msk.push_back(m);
        q_err.push_back(er);
        apb(1'b0, a, '0);
    endtask

    // Odd parity over bits 24..0, optionally broken
    task automatic send(input logic [3:0] code, input logic [19:0] d,
                        input logic bad);
        int n;
        hword <= {7'h00, ~^{code, d} ^ bad, code, d};
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        @(posedge pclk);
        n = 0;
        while (busy === 1'b1) begin
            @(posedge pclk);
            n++;
            if (n > 400) hang();
        end
        repeat (20) @(posedge pclk);
    endtask

    task automatic tick;
        basic_time_in <= 1'b1;
        repeat (8) @(posedge pclk);
        basic_time_in <= 1'b0;
        repeat (400) @(posedge pclk);
    endtask

    // Read results are matched against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (q_exp.size() == 0) hang();
            check(prdata & q_msk.pop_front(), q_exp.pop_front());
            check(pslverr, q_err.pop_front());
        end
        if (dt === 1'b1) dumps++;
        if (oe === 1'b1) drives++;
        if (al === 1'b1) lasts++;
        if (pp === 1'b1) presets++;
        if (bt === 1'b1) bts++;
        // Rising edges on each serial line, whole run
        for (int i = 0; i < 4; i++)
            if (so[i] === 1'b1 && so_d[i] === 1'b0) rises[i]++;
        so_d = so;
    end

    initial begin
        int n;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(su, 1'b1);
        n = 0;
        while (su !== 1'b0) begin
            @(posedge pclk);
            n++;
            if (n > 100) hang();
        end
        lf = lfsr(lf);
        il = lf[5:0] % 6'd54;
        // Right test index pinned on the one good delay word
        apb(1'b1, REG_CTRL, {18'h0, 6'h01, 2'h0, il});
        rd(REG_CTRL, {18'h0, 6'h01, 2'h0, il},
           32'h00003F3F, 1'b0);
        rd(8'h10, '0, 32'hFFFFFFFF, 1'b1);
        lf = lfsr(lf);
        cw = {8'h00, CODE_CONTROL, 4'h0, lf[15:3], 3'h1};
        send(CODE_CONTROL, cw[19:0], 1'b0);
        rd(REG_CONTROL_WORD, {7'h0, ~^cw[23:0], cw[23:0]},
           32'h00FFFFFF, 1'b0);
        lf = lfsr(lf);
        send(CODE_TIME, {4'h0, lf}, 1'b0);
        rd(REG_TIME, {7'h0, ~^{CODE_TIME, lf}, CODE_TIME, 4'h0, lf},
           32'hFFFFFFFF, 1'b0);
        rd(REG_CONTROL_WORD, {7'h0, ~^cw[23:0], cw[23:0]},
           32'h00FFFFFF, 1'b0);
        send(CODE_DELAY, {4'h0, lfsr(lf)}, 1'b1);
        rd(REG_STATUS, 32'h00000100, 32'h0000FF00, 1'b0);
        send(CODE_DELAY, 20'h00123, 1'b0);
        rd(REG_STATUS, 32'h00000100, 32'h0000FF00, 1'b0);
        rd(REG_STATUS, 32'h00000000, 32'h00000070, 1'b0);
        tick();
        rd(REG_STATUS, 32'h00000010, 32'h00000070, 1'b0);
        dumps = 0;
        drives = 0;
        presets = 0;
        lasts = 0;
        bts = 0;
        repeat (4) tick();
        check(dumps, 2);
        check(bts, 4);
        check(drives, 4);
        check(presets, 2);
        check(lasts, 4);
        check(tl, '0);
        check(tr, '0);
        // Whole set of 27 pairs takes about 14000 cycles
        n = 0;
        while (tr === '0) begin
            @(posedge pclk);
            n++;
            if (n > 20000) hang();
        end
        check(tr, 20'h0011E);
        check(tl, il == 6'h01 ? 20'h0011E : 20'hFFFFB);
        check(rises[3], 0);
        check(rises[2], 4);
        check(rises[1], 0);
        check(rises[0], 6);
        final_report();
    end
endmodule
`default_nettype wire
